// ===== temp_fmt_pkg.sv
// Shared constants and carrier types for the temperature result formatter
package temp_fmt_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_LOCAL = 8'h00;         // Local result
    localparam logic [7:0] ADDR_REM1_HIGH = 8'h01;     // Remote one high byte
    localparam logic [7:0] ADDR_REM1_LOW = 8'h10;      // Remote one low byte
    localparam logic [7:0] ADDR_REM2_HIGH = 8'h30;     // Remote two high byte
    localparam logic [7:0] ADDR_REM2_LOW = 8'h33;      // Remote two low byte
    localparam logic [7:0] ADDR_CFG1_RD = 8'h03;       // Configuration one, read side
    localparam logic [7:0] ADDR_CFG1_WR = 8'h09;       // Configuration one, write side

    // Configuration one fields and reset values
    localparam int CFG_ALIAS_BIT = 3;                  // channel_alias_select
    localparam int CFG_RANGE_BIT = 2;                  // Extended range select
    localparam logic [7:0] CFG1_RESET = 8'h00;         // Configuration one after reset
    localparam logic [7:0] VALUE_RESET = 8'h00;        // Value registers after reset

    // Conversion data: signed quarter degrees
    localparam int SAMPLE_W = 12;                      // Raw sample width
    localparam int AVG_LOG2 = 4;                       // Log2 of averaged samples
    localparam logic [3:0] AVG_LAST = 4'hF;            // Count of last averaged sample
    localparam int CODE_W = 10;                        // Formatted result width
    localparam int EXT_OFFSET_Q = 256;                 // 64 degrees in quarter steps
    localparam int BIN_MAX_Q = 511;                    // 127.75 degrees, binary top
    localparam int EXT_MAX_Q = 1023;                   // 191.75 degrees, extended top
    localparam int LOW_PAD = 6;                        // Zero bits under the fraction

    // Channel codes
    localparam logic [1:0] CH_LOCAL = 2'h0;            // Local sensor
    localparam logic [1:0] CH_REM1 = 2'h1;             // Remote one
    localparam logic [1:0] CH_REM2 = 2'h2;             // Remote two
    localparam int NUM_CH = 3;                         // Channel count

    // One finished conversion from the front end
    typedef struct packed {
        logic valid;                                   // One-cycle strobe
        logic [1:0] channel;                           // Channel code
        logic signed [SAMPLE_W-1:0] data;              // Quarter degrees, signed
    } conv_s;

    // One stored result towards the limit comparator
    typedef struct packed {
        logic valid;                                   // One-cycle strobe
        logic [1:0] channel;                           // Channel code
        logic [CODE_W-1:0] code;                       // Formatted code, quarter steps
    } result_s;

endpackage

// ===== temperature_result_formatter.sv
// Averaging, formatting and register read-out of temperature results
// How it works
// - Slow rates average sixteen consecutive samples
// - Fast rates report single samples directly
// - Local result is one whole-degree byte
// - Remote results split ten bits high/low
// - Result registers at fixed byte addresses
// - Alias bit set maps remote two high and low at remote one addresses
// - Alias bit clear shows remote one
// - Low byte uses bits 7,6 only
// - Low-byte read freezes high until read
// - Range bit picks binary or extended
// - Extended format adds sixty-four degrees offset
// - Next completed result uses new format
// - Range change leaves limit registers alone
// - Binary results clamp to 0..127
// - Extended codes span -64..+191 degrees
// - New results stored, offered to comparator
// - All registers are eight bits
// - Configuration one read 0x03, written 0x09
// - Value registers reset zero, read-only
`timescale 1ns/10ps

module temperature_result_formatter (
    input wire logic clk,                          // 25 MHz system clock
    input wire logic srst,                         // Synchronous reset, active high
    input wire temp_fmt_pkg::conv_s conv,          // Finished raw conversion
    input wire logic rateFast,                     // Conversion rate is 16/32/64 per second
    input wire logic [7:0] regAddr,                // Register address
    input wire logic regRead,                      // Read strobe
    input wire logic regWrite,                     // Write strobe
    input wire logic [7:0] regWdata,               // Write data
    output logic [7:0] regRdata,                   // Read data, one cycle after strobe
    output logic regRdValid,                       // Read data valid pulse
    output logic [7:0] configOne,                  // Configuration one contents
    output temp_fmt_pkg::result_s result           // Stored result for limit compare
);
    import temp_fmt_pkg::*;

    localparam int SUM_W = SAMPLE_W + AVG_LOG2;    // Accumulator width

    // Averaging state per channel
    logic signed [SUM_W-1:0] acc [NUM_CH];         // Running sums
    logic [3:0] cnt [NUM_CH];                      // Samples held in sum
    logic [NUM_CH-1:0] chDone;                     // Channel result completes now
    logic signed [SAMPLE_W-1:0] chValue [NUM_CH];  // Completed quarter-degree value

    // Stored registers
    logic [7:0] localVal;                          // Local result
    logic [7:0] remHigh [2];                       // Remote high bytes
    logic [1:0] remLow [2];                        // Remote fraction bits
    logic [7:0] heldHigh [2];                      // Frozen high bytes
    logic [1:0] locked;                            // High byte frozen flags

    // Formatting of the completing result
    logic doneAny;                                 // Some channel completed
    logic [1:0] doneCh;                            // Which channel
    logic signed [SAMPLE_W-1:0] doneValue;         // Its value
    logic [CODE_W-1:0] next_code;                  // Formatted code

    // Converts quarter degrees to a clamped binary or offset code
    function automatic logic [CODE_W-1:0] fmt_code(input logic signed [SAMPLE_W-1:0] q,
                                                   input logic ext);
        logic signed [SAMPLE_W+1:0] t;
        t = ext ? (SAMPLE_W+2)'(q) + (SAMPLE_W+2)'(EXT_OFFSET_Q) : (SAMPLE_W+2)'(q);
        if (t < 0) begin
            fmt_code = '0;
        end else if (!ext && t > (SAMPLE_W+2)'(BIN_MAX_Q)) begin
            fmt_code = CODE_W'(BIN_MAX_Q);
        end else if (t > (SAMPLE_W+2)'(EXT_MAX_Q)) begin
            fmt_code = CODE_W'(EXT_MAX_Q);
        end else begin
            fmt_code = t[CODE_W-1:0];
        end
    endfunction

    // Per-channel averaging filter
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gAvg
            logic hit;                                             // Sample for this channel
            logic signed [SUM_W-1:0] sum;                          // Sum including this sample
            assign hit = conv.valid && (conv.channel == 2'(g));
            assign sum = acc[g] + SUM_W'(conv.data);
            assign chDone[g] = hit && (rateFast || cnt[g] == AVG_LAST);
            assign chValue[g] = rateFast ? conv.data : sum[SUM_W-1:AVG_LOG2];

            // Sum sixteen samples, or stay idle at fast rates
            always_ff @(posedge clk) begin
                if (srst) begin
                    acc[g] <= '0;
                    cnt[g] <= '0;
                end else if (rateFast) begin
                    acc[g] <= '0;
                    cnt[g] <= '0;
                end else if (hit) begin
                    if (cnt[g] == AVG_LAST) begin
                        acc[g] <= '0;
                        cnt[g] <= '0;
                    end else begin
                        acc[g] <= sum;
                        cnt[g] <= cnt[g] + 4'h1;
                    end
                end
            end
        end
    endgenerate

    // Pick the completing channel and format it with the current range
    always_comb begin
        doneAny = |chDone;
        doneCh = CH_LOCAL;
        doneValue = chValue[0];
        if (chDone[1]) begin
            doneCh = CH_REM1;
            doneValue = chValue[1];
        end else if (chDone[2]) begin
            doneCh = CH_REM2;
            doneValue = chValue[2];
        end
        next_code = fmt_code(doneValue, configOne[CFG_RANGE_BIT]);
    end

    // Configuration one register
    always_ff @(posedge clk) begin
        if (srst) begin
            configOne <= CFG1_RESET;
        end else if (regWrite && regAddr == ADDR_CFG1_WR) begin
            configOne <= regWdata;
        end
    end

    // Value registers, written by conversions only
    always_ff @(posedge clk) begin
        if (srst) begin
            localVal <= VALUE_RESET;
            remHigh[0] <= VALUE_RESET;
            remHigh[1] <= VALUE_RESET;
            remLow[0] <= '0;
            remLow[1] <= '0;
        end else if (doneAny) begin
            case (doneCh)
                CH_LOCAL: begin
                    localVal <= next_code[CODE_W-1:2];
                end
                CH_REM1: begin
                    remHigh[0] <= next_code[CODE_W-1:2];
                    remLow[0] <= next_code[1:0];
                end
                CH_REM2: begin
                    remHigh[1] <= next_code[CODE_W-1:2];
                    remLow[1] <= next_code[1:0];
                end
                default: begin
                    localVal <= localVal;
                end
            endcase
        end
    end

    // Result offered to the limit comparator
    always_ff @(posedge clk) begin
        if (srst) begin
            result <= '0;
        end else begin
            result.valid <= doneAny;
            result.channel <= doneCh;
            result.code <= next_code;
        end
    end

    // Low-byte reads freeze the matching high byte until it is read
    always_ff @(posedge clk) begin
        if (srst) begin
            locked <= '0;
            heldHigh[0] <= VALUE_RESET;
            heldHigh[1] <= VALUE_RESET;
        end else if (regRead) begin
            case (regAddr)
                ADDR_REM1_LOW: begin
                    locked[configOne[CFG_ALIAS_BIT]] <= 1'b1;
                    heldHigh[configOne[CFG_ALIAS_BIT]] <= remHigh[configOne[CFG_ALIAS_BIT]];
                end
                ADDR_REM2_LOW: begin
                    locked[1] <= 1'b1;
                    heldHigh[1] <= remHigh[1];
                end
                ADDR_REM1_HIGH: begin
                    locked[configOne[CFG_ALIAS_BIT]] <= 1'b0;
                end
                ADDR_REM2_HIGH: begin
                    locked[1] <= 1'b0;
                end
                default: begin
                    locked <= locked;
                end
            endcase
        end
    end

    // Register read mux, answered on the next edge
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdata <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRead;
            if (regRead) begin
                case (regAddr)
                    ADDR_LOCAL: regRdata <= localVal;
                    ADDR_REM1_HIGH: begin
                        regRdata <= locked[configOne[CFG_ALIAS_BIT]] ?
                                    heldHigh[configOne[CFG_ALIAS_BIT]] :
                                    remHigh[configOne[CFG_ALIAS_BIT]];
                    end
                    ADDR_REM1_LOW: begin
                        regRdata <= {remLow[configOne[CFG_ALIAS_BIT]], LOW_PAD'(0)};
                    end
                    ADDR_REM2_HIGH: regRdata <= locked[1] ? heldHigh[1] : remHigh[1];
                    ADDR_REM2_LOW: regRdata <= {remLow[1], LOW_PAD'(0)};
                    ADDR_CFG1_RD: regRdata <= configOne;
                    default: regRdata <= 8'h00;                                     // Unmapped reads zero
                endcase
            end
        end
    end

    // Checks on the logic above
    // Slow-rate local samples before the sixteenth store nothing
    no_avg_early_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && !rateFast && conv.channel == CH_LOCAL && cnt[0] != AVG_LAST |=> !result.valid)
        else $error("Result stored before sixteen samples");

    // Fast-rate remote one samples store at once
    fast_direct_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && rateFast && conv.channel == CH_REM1 |=> result.valid && result.channel == CH_REM1)
        else $error("Fast sample not stored directly");

    // Sixteenth local sample stores a result and restarts the count
    avg_sixteen_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && !rateFast && conv.channel == CH_LOCAL && cnt[0] == AVG_LAST
        |=> result.valid && result.channel == CH_LOCAL && cnt[0] == 4'h0)
        else $error("Sixteenth sample did not complete");

    low_pad_a: assert property (@(posedge clk) disable iff (srst)
        regRead && (regAddr == ADDR_REM1_LOW || regAddr == ADDR_REM2_LOW) |=> regRdata[5:0] == 6'h00)
        else $error("Low byte padding not zero");

    binary_clamp_a: assert property (@(posedge clk) disable iff (srst)
        result.valid && !$past(configOne[CFG_RANGE_BIT]) |-> result.code <= CODE_W'(BIN_MAX_Q))
        else $error("Binary result above 127");

    // High byte read after a gap still shows the value frozen by the low read
    freeze_high_a: assert property (@(posedge clk) disable iff (srst)
        regRead && regAddr == ADDR_REM2_LOW ##1 !regRead [*3] ##1 regRead && regAddr == ADDR_REM2_HIGH
        |=> regRdata == $past(remHigh[1], 5))
        else $error("High byte not frozen by low read");

    alias_high_a: assert property (@(posedge clk) disable iff (srst)
        regRead && regAddr == ADDR_REM1_HIGH && configOne[CFG_ALIAS_BIT] && !locked[1]
        |=> regRdata == $past(remHigh[1]))
        else $error("Alias read did not return remote two");

    plain_high_a: assert property (@(posedge clk) disable iff (srst)
        regRead && regAddr == ADDR_REM1_HIGH && !configOne[CFG_ALIAS_BIT] && !locked[0]
        |=> regRdata == $past(remHigh[0]))
        else $error("Remote one read returned wrong byte");

    // A written configuration reads back at its read address
    cfg_write_a: assert property (@(posedge clk) disable iff (srst)
        regWrite && regAddr == ADDR_CFG1_WR ##1 !regWrite ##1 regRead && regAddr == ADDR_CFG1_RD
        |=> regRdata == $past(regWdata, 3))
        else $error("Configuration readback wrong");

    value_source_a: assert property (@(posedge clk) disable iff (srst)
        !$stable(localVal) |-> result.valid && result.channel == CH_LOCAL && localVal == result.code[CODE_W-1:2])
        else $error("Local value changed without a result");

    reset_zero_a: assert property (@(posedge clk)
        srst |=> localVal == VALUE_RESET && remHigh[0] == VALUE_RESET && remHigh[1] == VALUE_RESET)
        else $error("Value registers not zero after reset");

    ext_offset_a: assert property (@(posedge clk) disable iff (srst)
        doneAny && configOne[CFG_RANGE_BIT] && doneValue == '0 |=> result.code == CODE_W'(EXT_OFFSET_Q))
        else $error("Extended zero not offset by 64");

    // Every read strobe is answered on the next edge
    read_answer_a: assert property (@(posedge clk) disable iff (srst)
        regRead |=> regRdValid)
        else $error("Read strobe not answered");

    // Local reads return the stored whole-degree byte
    local_read_a: assert property (@(posedge clk) disable iff (srst)
        regRead && regAddr == ADDR_LOCAL |=> regRdata == $past(localVal))
        else $error("Local read returned wrong byte");

    // Writes elsewhere leave configuration one alone
    cfg_refuse_a: assert property (@(posedge clk) disable iff (srst)
        regWrite && regAddr != ADDR_CFG1_WR |=> $stable(configOne))
        else $error("Configuration changed by a foreign write");

    // Bus writes never reach the value registers
    values_readonly_a: assert property (@(posedge clk) disable iff (srst)
        regWrite && !doneAny |=> $stable(localVal) && $stable(remHigh[0]) && $stable(remHigh[1]))
        else $error("Value register changed by a bus write");

    // Remote one keeps high byte and fraction of one code
    remote_split_a: assert property (@(posedge clk) disable iff (srst)
        result.valid && result.channel == CH_REM1
        |-> remHigh[0] == result.code[CODE_W-1:2] && remLow[0] == result.code[1:0])
        else $error("Remote one bytes split wrongly");

    // Binary results below zero read as zero
    binary_floor_a: assert property (@(posedge clk) disable iff (srst)
        doneAny && !configOne[CFG_RANGE_BIT] && doneValue < 0 |=> result.code == '0)
        else $error("Binary result below zero not floored");

    // Extended results past the code space clamp to the top
    ext_top_a: assert property (@(posedge clk) disable iff (srst)
        doneAny && configOne[CFG_RANGE_BIT] && int'(doneValue) + EXT_OFFSET_Q > EXT_MAX_Q
        |=> result.code == CODE_W'(EXT_MAX_Q))
        else $error("Extended result not clamped at top");

    // A remote two low read arms the freeze
    lock_set_a: assert property (@(posedge clk) disable iff (srst)
        regRead && regAddr == ADDR_REM2_LOW |=> locked[1])
        else $error("Low read did not freeze high byte");

    // A remote two high read releases the freeze
    high_unlock_a: assert property (@(posedge clk) disable iff (srst)
        regRead && regAddr == ADDR_REM2_HIGH |=> !locked[1])
        else $error("High read did not release freeze");

    alias_read_c: cover property (@(posedge clk) disable iff (srst)
        regRead && regAddr == ADDR_REM1_LOW && configOne[CFG_ALIAS_BIT]);
    locked_read_c: cover property (@(posedge clk) disable iff (srst)
        regRead && regAddr == ADDR_REM1_HIGH && locked[0]);
    averaged_store_c: cover property (@(posedge clk) disable iff (srst)
        result.valid && !rateFast);
    extended_store_c: cover property (@(posedge clk) disable iff (srst)
        result.valid && configOne[CFG_RANGE_BIT]);
    // Frozen high byte handed out
    frozen_read_c: cover property (@(posedge clk) disable iff (srst)
        regRead && regAddr == ADDR_REM2_HIGH && locked[1]);

endmodule

// ===== reg_host_model.sv
// Register bus host model that reads results and writes configuration one
`timescale 1ns/10ps

module reg_host_model (
    input wire logic clk,                // System clock
    input wire logic [7:0] regRdata,     // Read data from the block
    input wire logic regRdValid,         // Read data valid pulse
    output logic [7:0] regAddr,          // Register address
    output logic regRead,                // Read strobe
    output logic regWrite,               // Write strobe
    output logic [7:0] regWdata          // Write data
);
    // Idle bus at time zero
    initial begin
        regAddr = 8'h00;
        regRead = 1'b0;
        regWrite = 1'b0;
        regWdata = 8'h00;
    end

    // One read: strobe taken at one edge, answer taken just after that same edge
    task automatic doRead(input logic [7:0] addr, output logic [7:0] data, output logic valid);
        @(posedge clk);
        #1;
        regAddr = addr;
        regRead = 1'b1;
        @(posedge clk);
        #1;
        regRead = 1'b0;
        regAddr = ~addr;                 // Address no longer qualified
        data = regRdata;
        valid = regRdValid;
    endtask

    // One write: strobe, address and data for a single edge
    task automatic doWrite(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #1;
        regAddr = addr;
        regWdata = data;
        regWrite = 1'b1;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        regAddr = ~addr;                 // Released lines stop showing the value
        regWdata = ~data;
    endtask

    // Full remote result: low byte first so the high byte stays coherent
    task automatic readRemote(input logic [7:0] lowAddr, input logic [7:0] highAddr,
                              output logic [7:0] lo, output logic [7:0] hi);
        logic v;
        doRead(lowAddr, lo, v);
        doRead(highAddr, hi, v);
    endtask
endmodule

// ===== test_temperature_result_formatter.sv
// Self-checking testbench of the temperature result formatter
`timescale 1ns/10ps

module test_temperature_result_formatter;
    import temp_fmt_pkg::*;

    logic clk = 1'b0;                    // 25 MHz clock
    logic srst = 1'b1;                   // Synchronous reset
    conv_s conv = '0;                    // Conversion input
    logic rateFast = 1'b1;               // Fast rate, no averaging
    logic [7:0] regAddr;                 // Bus address
    logic regRead;                       // Read strobe
    logic regWrite;                      // Write strobe
    logic [7:0] regWdata;                // Write data
    logic [7:0] regRdata;                // Read data
    logic regRdValid;                    // Read valid
    logic [7:0] configOne;               // Configuration one
    result_s result;                     // Stored result
    int fails = 0;                       // Mismatch count
    int n_compared = 0;                  // Comparison count
    int cycles = 0;                      // Cycle counter for the timeout
    logic [7:0] lo;                      // Scratch low byte
    logic [7:0] hi;                      // Scratch high byte
    logic [7:0] bytes[8] = '{ADDR_REM1_LOW, ADDR_REM1_HIGH, ADDR_REM2_LOW, ADDR_REM2_HIGH,
                             ADDR_LOCAL, ADDR_CFG1_RD, ADDR_CFG1_WR, 8'h55}; // Reset read order

    temperature_result_formatter u_temperature_result_formatter (.clk(clk), .srst(srst), .conv(conv),
        .rateFast(rateFast), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata),
        .regRdata(regRdata), .regRdValid(regRdValid), .configOne(configOne), .result(result));

    reg_host_model u_reg_host_model (.clk(clk), .regRdata(regRdata), .regRdValid(regRdValid),
        .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata));

    // Clock generator
    initial begin
        forever #20 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            summarize();
        end
    end

    // Byte comparison
    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: byte got %h expected %h", $time, got, exp);
        end
    endtask

    // Flag comparison
    task automatic checkBit(input logic got, input logic exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask

    // Single register read with expected value and valid pulse
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        u_reg_host_model.doRead(addr, d, v);
        checkBit(v, 1'b1);
        checkByte(d, exp);
    endtask

    // Remote pair read, low byte first
    task automatic rdPair(input logic [7:0] la, input logic [7:0] ha, input logic [7:0] el, input logic [7:0] eh);
        u_reg_host_model.readRemote(la, ha, lo, hi);
        checkByte(lo, el);
        checkByte(hi, eh);
    endtask

    // One conversion strobe; checks whether a result completes
    task automatic sendConv(input logic [1:0] ch, input logic signed [11:0] d, input logic expValid);
        @(posedge clk);
        #1;
        conv = {1'b1, ch, d};
        @(posedge clk);
        #1;
        conv = {1'b0, ch, ~d};
        checkBit(result.valid, expValid);
        if (expValid) begin
            checkByte(8'(result.channel), 8'(ch));
        end
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        foreach (bytes[i]) begin
            rd(bytes[i], VALUE_RESET);
        end
        u_reg_host_model.doWrite(ADDR_LOCAL, 8'hAA);
        rd(ADDR_LOCAL, 8'h00);
        u_reg_host_model.doWrite(ADDR_CFG1_WR, 8'h0C);
        rd(ADDR_CFG1_RD, 8'h0C);
        rd(ADDR_CFG1_WR, 8'h00);
        checkByte(configOne, 8'h0C);
        u_reg_host_model.doWrite(ADDR_CFG1_WR, 8'h00);
        sendConv(CH_LOCAL, 12'sh064, 1'b1);
        checkByte(result.code[9:2], 8'h19);
        rd(ADDR_LOCAL, 8'h19);
        sendConv(CH_REM1, 12'sh065, 1'b1);
        rdPair(ADDR_REM1_LOW, ADDR_REM1_HIGH, 8'h40, 8'h19);
        sendConv(CH_REM2, 12'sh0FF, 1'b1);
        rdPair(ADDR_REM2_LOW, ADDR_REM2_HIGH, 8'hC0, 8'h3F);
        sendConv(CH_REM1, -12'sh004, 1'b1);
        rdPair(ADDR_REM1_LOW, ADDR_REM1_HIGH, 8'h00, 8'h00);
        sendConv(CH_REM1, 12'sh258, 1'b1);
        rdPair(ADDR_REM1_LOW, ADDR_REM1_HIGH, 8'hC0, 8'h7F);
        rd(ADDR_REM1_HIGH, 8'h7F);
        rd(ADDR_REM2_LOW, 8'hC0);
        sendConv(CH_REM2, 12'sh190, 1'b1);
        rd(ADDR_REM2_HIGH, 8'h3F);
        rdPair(ADDR_REM2_LOW, ADDR_REM2_HIGH, 8'h00, 8'h64);
        u_reg_host_model.doWrite(ADDR_CFG1_WR, 8'h04);
        sendConv(CH_LOCAL, 12'sh000, 1'b1);
        rd(ADDR_LOCAL, 8'h40);
        sendConv(CH_REM1, -12'sh0DC, 1'b1);
        rdPair(ADDR_REM1_LOW, ADDR_REM1_HIGH, 8'h00, 8'h09);
        sendConv(CH_REM1, -12'sh12C, 1'b1);
        rdPair(ADDR_REM1_LOW, ADDR_REM1_HIGH, 8'h00, 8'h00);
        sendConv(CH_REM1, 12'sh44C, 1'b1);
        u_reg_host_model.doWrite(ADDR_CFG1_WR, 8'h0C);
        sendConv(CH_REM2, 12'sh001, 1'b1);
        rdPair(ADDR_REM1_LOW, ADDR_REM1_HIGH, 8'h40, 8'h40);
        rd(ADDR_REM1_HIGH, 8'h40);
        u_reg_host_model.doWrite(ADDR_CFG1_WR, 8'h04);
        rdPair(ADDR_REM1_LOW, ADDR_REM1_HIGH, 8'hC0, 8'hFF);
        u_reg_host_model.doWrite(ADDR_CFG1_WR, 8'h00);
        rateFast = 1'b0;
        for (int k = 0; k < 15; k++) begin
            sendConv(CH_LOCAL, 12'(4 * (20 + k)), 1'b0);
        end
        rd(ADDR_LOCAL, 8'h40);
        sendConv(CH_LOCAL, 12'sh08C, 1'b1);
        rd(ADDR_LOCAL, 8'h1B);
        summarize();
    end
endmodule
